// File: sfw_pkg.sv
// Shared constants for the slave FIFO write port, both ends
package sfw_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int SEL_W  = 2;
  localparam int NUM_EP = 4;
  localparam int DEPTH  = 16;
  localparam int IDX_W  = 4;
  localparam int CNT_W  = 5;
  localparam int TMR_W  = 8;

  // ----------------------------------------------------------------
  // Reset and limit values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST        = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE        = 5'h01;
  localparam logic [CNT_W-1:0] FULL_CNT       = 5'h10;
  // Order is {clock, chip select, write strobe, commit strobe}, strobes high
  localparam logic [3:0]       LINK_CTRL_IDLE = 4'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS         = 100;
  localparam int LINK_PERIOD_NS        = 800;
  localparam int LINK_HALF_CYC         = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SELECT_SETUP_NS       = 10;
  localparam int WRITE_ACTIVE_NS       = 50;
  localparam int WRITE_INACTIVE_NS     = 50;
  localparam int COMMIT_ACTIVE_NS      = 50;
  localparam int SELECT_SETUP_CYC      = (SELECT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_ACTIVE_CYC      = (WRITE_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_INACTIVE_CYC    = (WRITE_INACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COMMIT_ACTIVE_CYC     = (COMMIT_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: sfw_link_if.sv
// Pins between the external master and the slave FIFO write port
`timescale 1ns/1ps
interface sfw_link_if;
  logic                       interface_clock;
  logic                       fifo_chip_select_n;
  logic                       fifo_write_strobe_n;
  logic                       packet_commit_strobe_n;
  logic [sfw_pkg::SEL_W-1:0]  fifo_select_lines;
  logic [sfw_pkg::DATA_W-1:0] fifo_data;
  logic                       fifo_full;
  logic                       fifo_empty;

  modport dev (
    input  interface_clock,
    input  fifo_chip_select_n,
    input  fifo_write_strobe_n,
    input  packet_commit_strobe_n,
    input  fifo_select_lines,
    input  fifo_data,
    output fifo_full,
    output fifo_empty
  );

  modport mst (
    output interface_clock,
    output fifo_chip_select_n,
    output fifo_write_strobe_n,
    output packet_commit_strobe_n,
    output fifo_select_lines,
    output fifo_data,
    input  fifo_full,
    input  fifo_empty
  );
endinterface

// File: sfw_dev_end.sv
// Device end: endpoint FIFOs, packet commit and drain to the host side
`timescale 1ns/1ps
// Contract
// (RULE1) Master holds select and strobe through bursts
// (RULE2) Sync mode captures data each clock edge
// (RULE3) Sync mode advances pointer per captured value
// (RULE4) Commit strobe sends held data as packet
// (RULE5) Master may commit with last value or later
// (RULE6) Same-edge value belongs to committed packet
// (RULE7) Master holds select lines during commit
// (RULE8) Auto mode commits when count hits length
// (RULE9) Master spaces short commit after auto packet
// (RULE10) Async master sets select before strobe
// (RULE11) Async chip select no later than strobe
// (RULE12) Async data valid before strobe release
// (RULE13) Async write on release, then pointer advance
// (RULE14) Async flags update after each release
// (RULE15) Async master never overlaps write and commit
// (RULE16) Async commit after strobe inactive width
// (RULE17) Sync write needs select and strobe both
// (RULE18) Deselected strobes are ignored entirely
// (RULE19) Writes into a full FIFO are dropped
module sfw_dev_end (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  sfw_link_if.dev                          link,
  input  wire logic                        async_mode,
  input  wire logic                        auto_mode,
  input  wire logic [sfw_pkg::CNT_W-1:0]   auto_commit_length,
  output logic      [sfw_pkg::DATA_W-1:0]  out_data,
  output logic      [sfw_pkg::SEL_W-1:0]   out_ep,
  output logic                             out_last,
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic                             packet_committed,
  output logic                             write_dropped
);
  import sfw_pkg::*;

  localparam int PIN_W = 4 + SEL_W + DATA_W;
  localparam int ENT_W = SEL_W + 1 + DATA_W;

  typedef enum {DR_IDLE, DR_SEND} sfw_drain_t;

  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  s1_q;
  logic [PIN_W-1:0]  s2_q;
  logic              clk_s;
  logic              cs_n_s;
  logic              wr_n_s;
  logic              pe_n_s;
  logic [SEL_W-1:0]  sel_s;
  logic [DATA_W-1:0] dat_s;
  logic              clk_p_q;
  logic              wr_p_q;
  logic              pe_p_q;
  logic              clk_rise;
  logic              wr_rise;
  logic              pe_fall;
  logic              wr_ev;
  logic              pe_ev;
  logic [CNT_W-1:0]  cnt_q [NUM_EP];
  logic [NUM_EP-1:0] done_q;
  logic [DATA_W-1:0] mem_q [NUM_EP][DEPTH];
  logic [CNT_W-1:0]  cur_cnt;
  logic [CNT_W-1:0]  new_cnt;
  logic              full_sel;
  logic              do_wr;
  logic              commit_now;
  sfw_drain_t        state_q;
  logic [SEL_W-1:0]  drain_ep_q;
  logic [IDX_W-1:0]  rd_idx_q;
  logic [IDX_W-1:0]  last_idx_q;
  logic              pick_any;
  logic [SEL_W-1:0]  pick_ep;
  logic [CNT_W-1:0]  pick_m1;
  logic              push;
  logic              fin;
  logic [ENT_W-1:0]  push_ent;
  logic [ENT_W-1:0]  head_q;
  logic [ENT_W-1:0]  tail_q;
  logic              head_v_q;
  logic              tail_v_q;
  logic              buf_in_ready;
  logic              pop;
  logic              fifo_full_q;
  logic              fifo_empty_q;
  logic              commit_q;
  logic              drop_q;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Data goes through the same two stages as the clock, so a sampled
  // edge always sees the value that stood around it.
  assign pin_raw = {link.interface_clock, link.fifo_chip_select_n, link.fifo_write_strobe_n,
                    link.packet_commit_strobe_n, link.fifo_select_lines, link.fifo_data};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= {LINK_CTRL_IDLE, {(SEL_W + DATA_W){1'b0}}};
      s2_q <= {LINK_CTRL_IDLE, {(SEL_W + DATA_W){1'b0}}};
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  assign clk_s  = s2_q[PIN_W-1];
  assign cs_n_s = s2_q[PIN_W-2];
  assign wr_n_s = s2_q[PIN_W-3];
  assign pe_n_s = s2_q[PIN_W-4];
  assign sel_s  = s2_q[DATA_W +: SEL_W];
  assign dat_s  = s2_q[DATA_W-1:0];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_p_q <= LINK_CTRL_IDLE[3];
      wr_p_q  <= LINK_CTRL_IDLE[1];
      pe_p_q  <= LINK_CTRL_IDLE[0];
    end else begin
      clk_p_q <= clk_s;
      wr_p_q  <= wr_n_s;
      pe_p_q  <= pe_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  assign clk_rise = clk_s & ~clk_p_q;
  assign wr_rise  = wr_n_s & ~wr_p_q;
  assign pe_fall  = ~pe_n_s & pe_p_q;

  // (RULE2) (RULE17) (RULE18) (RULE13) Write event per mode
  assign wr_ev = ~cs_n_s & (async_mode ? wr_rise : (clk_rise & ~wr_n_s));
  // (RULE4) (RULE18) Commit event per mode
  assign pe_ev = ~cs_n_s & (async_mode ? pe_fall : (clk_rise & ~pe_n_s));

  assign cur_cnt  = cnt_q[sel_s];
  // (RULE19) Full or awaiting drain
  assign full_sel = done_q[sel_s] | (cur_cnt == FULL_CNT);
  assign do_wr    = wr_ev & ~full_sel;
  assign new_cnt  = cur_cnt + {{(CNT_W-1){1'b0}}, do_wr};

  // (RULE6) (RULE8) Count includes a same-edge value
  assign commit_now = ~done_q[sel_s] & (new_cnt != CNT_RST) &
                      (pe_ev | (auto_mode & do_wr & (new_cnt == auto_commit_length)));

  // ----------------------------------------------------------------
  // Endpoint storage
  // ----------------------------------------------------------------
  // (RULE2) (RULE13) Store at the current pointer
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_q[sel_s][cur_cnt[IDX_W-1:0]] <= dat_s;
    end
  end

  // (RULE3) (RULE13) (RULE19) Pointer advance after the store
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        cnt_q[i] <= CNT_RST;
      end
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (fin && drain_ep_q == SEL_W'(i)) begin
          cnt_q[i] <= CNT_RST;
        end else if (do_wr && sel_s == SEL_W'(i)) begin
          cnt_q[i] <= new_cnt;
        end
      end
    end
  end

  // (RULE4) (RULE8) Mark a packet ready for the host
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_q <= '0;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (commit_now && sel_s == SEL_W'(i)) begin
          done_q[i] <= 1'b1;
        end else if (fin && drain_ep_q == SEL_W'(i)) begin
          done_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Drain of committed packets
  // ----------------------------------------------------------------
  // Lowest endpoint first; a busy host can starve higher ones
  always_comb begin
    pick_any = 1'b0;
    pick_ep  = '0;
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (done_q[i]) begin
        pick_any = 1'b1;
        pick_ep  = SEL_W'(i);
      end
    end
  end

  assign pick_m1  = cnt_q[pick_ep] - CNT_ONE;
  assign push     = (state_q == DR_SEND) & buf_in_ready;
  assign fin      = push & (rd_idx_q == last_idx_q);
  assign push_ent = {drain_ep_q, rd_idx_q == last_idx_q, mem_q[drain_ep_q][rd_idx_q]};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q    <= DR_IDLE;
      drain_ep_q <= '0;
      rd_idx_q   <= '0;
      last_idx_q <= '0;
    end else begin
      case (state_q)
        DR_IDLE: begin
          if (pick_any) begin
            drain_ep_q <= pick_ep;
            rd_idx_q   <= '0;
            last_idx_q <= pick_m1[IDX_W-1:0];
            state_q    <= DR_SEND;
          end
        end
        DR_SEND: begin
          if (push) begin
            rd_idx_q <= rd_idx_q + 4'h1;
          end
          if (fin) begin
            state_q <= DR_IDLE;
          end
        end
        default: begin
          state_q <= DR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------
  assign buf_in_ready = ~tail_v_q;
  assign pop          = head_v_q & out_ready;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      head_q   <= '0;
      tail_q   <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end else begin
      if (pop) begin
        head_q   <= tail_q;
        head_v_q <= tail_v_q;
        tail_v_q <= 1'b0;
      end
      if (push) begin
        if (!head_v_q || (pop && !tail_v_q)) begin
          head_q   <= push_ent;
          head_v_q <= 1'b1;
        end else begin
          tail_q   <= push_ent;
          tail_v_q <= 1'b1;
        end
      end
    end
  end

  assign out_valid = head_v_q;
  assign out_data  = head_q[DATA_W-1:0];
  assign out_last  = head_q[DATA_W];
  assign out_ep    = head_q[ENT_W-1 -: SEL_W];

  // ----------------------------------------------------------------
  // Flags and event pulses
  // ----------------------------------------------------------------
  // (RULE14) Flags follow the store by one cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fifo_full_q  <= 1'b0;
      fifo_empty_q <= 1'b1;
      commit_q     <= 1'b0;
      drop_q       <= 1'b0;
    end else begin
      fifo_full_q  <= full_sel;
      fifo_empty_q <= (cur_cnt == CNT_RST);
      commit_q     <= commit_now;
      drop_q       <= wr_ev & full_sel;
    end
  end

  assign link.fifo_full   = fifo_full_q;
  assign link.fifo_empty  = fifo_empty_q;
  assign packet_committed = commit_q;
  assign write_dropped    = drop_q;

endmodule

// File: sfw_mst_end.sv
// Master end: drives strobes, select, data and the interface clock
`timescale 1ns/1ps
module sfw_mst_end (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  sfw_link_if.mst                          link,
  input  wire logic                        async_mode,
  input  wire logic [sfw_pkg::SEL_W-1:0]   user_sel,
  input  wire logic                        wr_valid,
  input  wire logic [sfw_pkg::DATA_W-1:0]  wr_data,
  output logic                             wr_ready,
  input  wire logic                        commit_req,
  output logic                             commit_ready,
  output logic                             link_full,
  output logic                             link_empty
);
  import sfw_pkg::*;

  typedef enum {M_IDLE, M_SETUP, M_ACTIVE, M_RECOVER} sfw_mst_t;

  logic [TMR_W-1:0]  div_q;
  logic              lclk_q;
  logic              fall_now;
  logic              pre_fall;
  logic              take_wr;
  logic              take_pe;
  logic              wr_ready_q;
  logic              commit_ready_q;
  sfw_mst_t          st_q;
  logic [TMR_W-1:0]  tmr_q;
  logic              op_pe_q;
  logic              cs_n_q;
  logic              wr_n_q;
  logic              pe_n_q;
  logic [SEL_W-1:0]  sel_q;
  logic [DATA_W-1:0] data_q;
  logic [1:0]        f1_q;
  logic [1:0]        f2_q;

  // ----------------------------------------------------------------
  // Interface clock divider
  // ----------------------------------------------------------------
  // Free running; in sync mode pins change on its falling edge, half a period of setup
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_q  <= '0;
      lclk_q <= 1'b0;
    end else if (div_q == TMR_W'(LINK_HALF_CYC - 1)) begin
      div_q  <= '0;
      lclk_q <= ~lclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign fall_now = lclk_q & (div_q == TMR_W'(LINK_HALF_CYC - 1));
  assign pre_fall = lclk_q & (div_q == TMR_W'(LINK_HALF_CYC - 2));

  // ----------------------------------------------------------------
  // User handshake
  // ----------------------------------------------------------------
  assign take_wr = wr_valid & wr_ready_q;
  // (RULE5) (RULE15) Sync may pair commit with a write; async never
  assign take_pe = commit_req & commit_ready_q & ~(async_mode & wr_valid);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ready_q     <= 1'b0;
      commit_ready_q <= 1'b0;
    end else if (async_mode) begin
      wr_ready_q     <= (st_q == M_IDLE) & ~(take_wr | take_pe);
      commit_ready_q <= (st_q == M_IDLE) & ~(take_wr | take_pe);
    end else begin
      wr_ready_q     <= pre_fall;
      commit_ready_q <= pre_fall;
    end
  end

  // ----------------------------------------------------------------
  // Pin sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q    <= M_IDLE;
      tmr_q   <= '0;
      op_pe_q <= 1'b0;
      cs_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      pe_n_q  <= 1'b1;
      sel_q   <= '0;
      data_q  <= '0;
    end else if (!async_mode) begin
      st_q <= M_IDLE;
      // (RULE1) (RULE7) Back-to-back takes keep select and strobe low
      if (fall_now) begin
        wr_n_q <= ~take_wr;
        pe_n_q <= ~take_pe;
        cs_n_q <= ~(take_wr | take_pe);
        if (take_wr | take_pe) begin
          sel_q <= user_sel;
        end
        if (take_wr) begin
          data_q <= wr_data;
        end
      end
    end else begin
      case (st_q)
        // (RULE10) (RULE11) (RULE12) Select, chip select, data first
        M_IDLE: begin
          if (take_wr | take_pe) begin
            sel_q   <= user_sel;
            cs_n_q  <= 1'b0;
            op_pe_q <= take_pe;
            tmr_q   <= TMR_W'(SELECT_SETUP_CYC - 1);
            st_q    <= M_SETUP;
            if (take_wr) begin
              data_q <= wr_data;
            end
          end
        end
        M_SETUP: begin
          if (tmr_q == '0) begin
            wr_n_q <= op_pe_q;
            pe_n_q <= ~op_pe_q;
            tmr_q  <= op_pe_q ? TMR_W'(COMMIT_ACTIVE_CYC - 1) : TMR_W'(WRITE_ACTIVE_CYC - 1);
            st_q   <= M_ACTIVE;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        M_ACTIVE: begin
          if (tmr_q == '0) begin
            wr_n_q <= 1'b1;
            pe_n_q <= 1'b1;
            tmr_q  <= TMR_W'(WRITE_INACTIVE_CYC - 1);
            st_q   <= M_RECOVER;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        // (RULE16) (RULE7) Inactive gap with select still held
        M_RECOVER: begin
          if (tmr_q == '0) begin
            cs_n_q <= 1'b1;
            st_q   <= M_IDLE;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        default: begin
          st_q <= M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flag synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      f1_q <= 2'h1;
      f2_q <= 2'h1;
    end else begin
      f1_q <= {link.fifo_full, link.fifo_empty};
      f2_q <= f1_q;
    end
  end

  assign link.interface_clock        = lclk_q;
  assign link.fifo_chip_select_n     = cs_n_q;
  assign link.fifo_write_strobe_n    = wr_n_q;
  assign link.packet_commit_strobe_n = pe_n_q;
  assign link.fifo_select_lines      = sel_q;
  assign link.fifo_data              = data_q;
  assign wr_ready                    = wr_ready_q;
  assign commit_ready                = commit_ready_q;
  assign link_full                   = f2_q[1];
  assign link_empty                  = f2_q[0];

endmodule

// File: sfw_link_checker.sv
// Wire-level checks on the slave FIFO write link
`timescale 1ns/1ps
module sfw_link_checker (
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire logic                       async_mode,
  input wire logic                       interface_clock,
  input wire logic                       fifo_chip_select_n,
  input wire logic                       fifo_write_strobe_n,
  input wire logic                       packet_commit_strobe_n,
  input wire logic [sfw_pkg::SEL_W-1:0]  fifo_select_lines,
  input wire logic [sfw_pkg::DATA_W-1:0] fifo_data,
  input wire logic                       fifo_full,
  input wire logic                       fifo_empty
);
  import sfw_pkg::*;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // Quiet time on the link
  // ------------------------------
  logic [3:0]       quiet_q;
  logic [SEL_W-1:0] sel_q;
  always_ff @(posedge core_clk) begin
    sel_q <= fifo_select_lines;
  end
  // Flags lag the pins by the synchronisers, hence the slack of six
  always_ff @(posedge core_clk) begin
    if (!rst_n || !fifo_chip_select_n || fifo_select_lines != sel_q) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  commit_sel_a: assert property (
    !packet_commit_strobe_n && !$past(packet_commit_strobe_n) |-> $stable(fifo_select_lines))
    else $error("select moved in commit");
  async_overlap_a: assert property (
    async_mode |-> fifo_write_strobe_n || packet_commit_strobe_n)
    else $error("write and commit together");
  async_hold_a: assert property (
    async_mode && !fifo_write_strobe_n |-> !fifo_chip_select_n && $stable(fifo_select_lines)
    && $stable(fifo_data) ##1 !fifo_chip_select_n && $stable(fifo_data))
    else $error("async write framing broken");
  commit_gap_a: assert property (
    async_mode && $fell(packet_commit_strobe_n) |-> $past(fifo_write_strobe_n)
    && $past(fifo_write_strobe_n, 2))
    else $error("commit too close to write");
  sync_slot_a: assert property (
    !async_mode && ($changed(fifo_chip_select_n) || $changed(fifo_write_strobe_n))
    |-> $fell(interface_clock))
    else $error("strobe moved off slot");
  flag_cause_a: assert property (
    $fell(fifo_empty) || $rose(fifo_full) |-> quiet_q < 4'h6)
    else $error("flags moved while deselected");
  sync_write_a: assert property (
    !async_mode && $fell(interface_clock) && !fifo_chip_select_n && !fifo_write_strobe_n
    && !fifo_full |-> ##[1:10] !fifo_empty)
    else $error("sync word not stored");
  sync_commit_a: assert property (
    !async_mode && $fell(interface_clock) && !fifo_chip_select_n && !packet_commit_strobe_n
    && !fifo_full && (!fifo_empty || !fifo_write_strobe_n) |-> ##[1:10] fifo_full)
    else $error("commit not taken");
  async_write_a: assert property (
    async_mode && $rose(fifo_write_strobe_n) && !fifo_chip_select_n && !fifo_full
    |-> ##[1:6] !fifo_empty)
    else $error("async word not stored");
endmodule

// File: tb_slave_fifo_write_port.sv
// Testbench joining master end and device end across the link
`timescale 1ns/1ps
module tb_slave_fifo_write_port;
  import sfw_pkg::*;
  logic              core_clk, rst_n, async_mode, auto_mode, wr_valid, commit_req, out_ready;
  logic [CNT_W-1:0]  auto_commit_length;
  logic [SEL_W-1:0]  user_sel;
  logic [DATA_W-1:0] wr_data;
  logic              wr_ready, commit_ready, link_full, link_empty, out_valid, out_last;
  logic              packet_committed, write_dropped;
  logic [DATA_W-1:0] out_data;
  logic [SEL_W-1:0]  out_ep;
  logic [18:0]       rxq[$];
  int                mismatches = 0, n_tests = 0, n_drop = 0, n_pkt = 0, cyc = 0;
  sfw_link_if link ();
  sfw_mst_end i_sfw_mst_end (.core_clk(core_clk), .rst_n(rst_n), .link(link), .async_mode(async_mode),
    .user_sel(user_sel), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .commit_req(commit_req), .commit_ready(commit_ready), .link_full(link_full), .link_empty(link_empty));
  sfw_dev_end i_sfw_dev_end (.core_clk(core_clk), .rst_n(rst_n), .link(link), .async_mode(async_mode),
    .auto_mode(auto_mode), .auto_commit_length(auto_commit_length), .out_data(out_data), .out_ep(out_ep),
    .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready),
    .packet_committed(packet_committed), .write_dropped(write_dropped));
  sfw_link_checker i_sfw_link_checker (.core_clk(core_clk), .rst_n(rst_n), .async_mode(async_mode),
    .interface_clock(link.interface_clock), .fifo_chip_select_n(link.fifo_chip_select_n),
    .fifo_write_strobe_n(link.fifo_write_strobe_n), .packet_commit_strobe_n(link.packet_commit_strobe_n),
    .fifo_select_lines(link.fifo_select_lines), .fifo_data(link.fifo_data),
    .fifo_full(link.fifo_full), .fifo_empty(link.fifo_empty));
  // ------------------------------
  // Clock, monitor and tasks
  // ------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (out_valid === 1'b1 && out_ready === 1'b1) rxq.push_back({out_ep, out_last, out_data});
    if (write_dropped === 1'b1) n_drop++;
    if (packet_committed === 1'b1) n_pkt++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until the ready edge takes it
  task automatic push(input logic [1:0] s, input logic [15:0] d, input logic w, input logic c);
    int k;
    @(negedge core_clk);
    user_sel = s;
    wr_data = d;
    wr_valid = w;
    commit_req = c;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((w ? wr_ready : commit_ready) !== 1'b1 && k < 64);
    if (k >= 64) mismatches++;
  endtask
  task automatic idle();
    @(negedge core_clk);
    wr_valid = 1'b0;
    commit_req = 1'b0;
  endtask
  task automatic burst(input logic [1:0] s, input logic [15:0] b, input int n, input logic c);
    for (int i = 0; i < n; i++) push(s, b + 16'(i), 1'b1, c && i == n - 1);
    idle();
  endtask
  // Whole packet expected in write order, last flag on final word
  task automatic recv(input logic [1:0] ep, input int n, input logic [15:0] b);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (rxq.size() == 0 && k < 200) begin
        @(posedge core_clk);
        k++;
      end
      chk("rx", (rxq.size() != 0) ? rxq.pop_front() : 19'hxxxxx, {ep, i == n - 1, b + 16'(i)});
    end
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    rst_n = 1'b0;
    async_mode = 1'b0;
    auto_mode = 1'b0;
    auto_commit_length = 5'h00;
    wr_valid = 1'b0;
    commit_req = 1'b0;
    user_sel = 2'h0;
    wr_data = 16'h0000;
    out_ready = 1'b1;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    burst(2'h1, 16'h1100, 1, 1'b0);
    burst(2'h1, 16'h1101, 3, 1'b0);
    push(2'h1, 16'h0000, 1'b0, 1'b1);
    idle();
    recv(2'h1, 4, 16'h1100);
    // commit with last word, receiver stalled
    // Three words, so the full buffer holds back the last and the packet stays owed
    @(negedge core_clk);
    out_ready = 1'b0;
    burst(2'h2, 16'h2200, 3, 1'b1);
    repeat (30) @(posedge core_clk);
    chk("held", 19'(link_full), 19'h00001);
    @(negedge core_clk);
    out_ready = 1'b1;
    recv(2'h2, 3, 16'h2200);
    @(negedge core_clk);
    auto_mode = 1'b1;
    auto_commit_length = 5'h03;
    burst(2'h0, 16'h3300, 3, 1'b0);
    recv(2'h0, 3, 16'h3300);
    burst(2'h0, 16'h3303, 1, 1'b0);
    push(2'h0, 16'h0000, 1'b0, 1'b1);
    idle();
    recv(2'h0, 1, 16'h3303);
    @(negedge core_clk);
    auto_mode = 1'b0;
    burst(2'h3, 16'h4400, 17, 1'b0);
    repeat (12) @(posedge core_clk);
    chk("full", 19'(link_full), 19'h00001);
    chk("drops", 19'(n_drop), 19'h00001);
    push(2'h3, 16'h0000, 1'b0, 1'b1);
    idle();
    recv(2'h3, 16, 16'h4400);
    @(negedge core_clk);
    async_mode = 1'b1;
    burst(2'h1, 16'h5500, 2, 1'b0);
    repeat (10) @(posedge core_clk);
    chk("empty", 19'(link_empty), 19'h00000);
    push(2'h1, 16'h0000, 1'b0, 1'b1);
    idle();
    recv(2'h1, 2, 16'h5500);
    chk("packets", 19'(n_pkt), 19'h00006);
    close_out();
  end
endmodule
